/* File: verilog/led_channel_shift_latch.sv */
// How it works
// RULE1 - supply lockout holds all logic in reset; the synchroniser stages obey only RESET
// RULE2 - power-up clears every shift stage
// RULE3 - rising shift clock shifts serial_in in
// RULE4 - newest bit drives channel 0, oldest 9
// RULE5 - cascade_out follows last stage, channel 9
// RULE6 - cascade_out is input delayed ten clocks
// RULE7 - cascade_out zero until register refilled
// RULE8 - high latch_transfer makes latch transparent
// RULE9 - low latch_transfer freezes channel latch
// RULE10 - output_blank high forces all switches off
// RULE11 - blank low, switches follow latch bits
// RULE12 - controller must drive output_blank low
// RULE13 - battery over-voltage disables all outputs; only the switches go off, cascade_out keeps following the last stage
// RULE14 - controller sends ten times N clocks
// RULE15 - cascaded devices chain and share clock
// RULE16 - register on shift clock, latch level-gated
// RULE17 - detectors arrive as digital input flags
module led_channel_shift_latch
    import led_latch_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic SHIFT_CLK,
    input wire logic SERIAL_IN,
    input wire logic LATCH_TRANSFER,
    input wire logic OUTPUT_BLANK,
    input wire logic BATTERY_SENSE,
    input wire logic SUPPLY_LOCKOUT,
    output logic CASCADE_OUT,
    output logic [CHAN_COUNT-1:0] CHANNEL_SWITCHES
);

    // pin bundle as it arrives and after each synchroniser stage
    pin_in_t pins_raw;
    pin_in_t sync_a_r;
    pin_in_t sync_a_nxt;
    pin_in_t sync_b_r;
    pin_in_t sync_b_nxt;
    pin_in_t pins;

    // internal reset
    logic lockout_now;
    logic logic_reset;

    // shift clock edge detect
    logic shift_clk_now;
    logic shift_clk_prev_r;
    logic shift_clk_prev_nxt;
    logic shift_armed_r;
    logic shift_armed_nxt;
    logic shift_rise;

    // shift register stages
    logic serial_bit;
    logic [CHAN_COUNT-1:0] stage_in;
    logic [CHAN_COUNT-1:0] shift_r;
    logic [CHAN_COUNT-1:0] shift_nxt;

    // channel latch
    logic latch_open;
    logic [CHAN_COUNT-1:0] latch_r;
    logic [CHAN_COUNT-1:0] latch_nxt;

    // switch gating
    logic blank_off;
    logic battery_off;
    logic outputs_off;
    logic [CHAN_COUNT-1:0] chan_on;
    logic [CHAN_COUNT-1:0] switch_nxt;

    // cascade output
    logic cascade_nxt;

    // gather the raw pins into one bundle
    assign pins_raw.shift_clk = SHIFT_CLK;
    assign pins_raw.serial_in = SERIAL_IN;
    assign pins_raw.latch_transfer = LATCH_TRANSFER;
    assign pins_raw.output_blank = OUTPUT_BLANK;
    assign pins_raw.battery_sense = BATTERY_SENSE;
    assign pins_raw.supply_lockout = SUPPLY_LOCKOUT; // RULE17

    // first synchroniser stage
    assign sync_a_nxt = pins_raw;

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            sync_a_r <= PIN_IN_CLEAR;
        end
        else
        begin
            sync_a_r <= sync_a_nxt;
        end
    end

    // second stage, the only reader of the first
    assign sync_b_nxt = sync_a_r;

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            sync_b_r <= PIN_IN_CLEAR;
        end
        else
        begin
            sync_b_r <= sync_b_nxt;
        end
    end

    // synchronised view used by all logic below
    assign pins = sync_b_r;

    // lockout flag resets the rest of the logic
    assign lockout_now = pins.supply_lockout;
    assign logic_reset = RESET | lockout_now; // RULE1

    // previous sample of the shift clock
    assign shift_clk_now = pins.shift_clk;
    assign shift_clk_prev_nxt = shift_clk_now;

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            shift_clk_prev_r <= 1'b0;
        end
        else
        begin
            shift_clk_prev_r <= shift_clk_nxt_hold();
        end
    end

    // armed once the shift clock is seen low after reset
    assign shift_armed_nxt = shift_armed_r | ~shift_clk_now;

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            shift_armed_r <= 1'b0;
        end
        else
        begin
            shift_armed_r <= shift_armed_nxt;
        end
    end

    // rising edge, never a clock left high across reset
    assign shift_rise = shift_clk_now & ~shift_clk_prev_r & shift_armed_r; // RULE16

    // stage 0 takes serial_in, every other stage the one below
    assign serial_bit = pins.serial_in;
    assign stage_in[0] = serial_bit; // RULE3

    generate
        for (genvar g = 1; g < CHAN_COUNT; g++)
        begin : g_stage_in
            assign stage_in[g] = shift_r[g-1];
        end
    endgenerate

    // every stage moves up one on a detected rise
    generate
        for (genvar g = 0; g < CHAN_COUNT; g++)
        begin : g_shift
            logic keep_bit;
            logic take_bit;

            assign keep_bit = shift_r[g];
            assign take_bit = stage_in[g];
            assign shift_nxt[g] = shift_rise ? take_bit : keep_bit;
        end
    endgenerate

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            shift_r <= CHAN_CLEAR; // RULE2 RULE7
        end
        else
        begin
            shift_r <= shift_nxt;
        end
    end

    // transparent while latch_transfer is high, held while low
    assign latch_open = pins.latch_transfer; // RULE8 RULE9

    generate
        for (genvar g = 0; g < CHAN_COUNT; g++)
        begin : g_latch
            logic hold_bit;
            logic pass_bit;

            assign hold_bit = latch_r[g];
            assign pass_bit = shift_nxt[g];
            assign latch_nxt[g] = latch_open ? pass_bit : hold_bit;
        end
    endgenerate

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            latch_r <= CHAN_CLEAR;
        end
        else
        begin
            latch_r <= latch_nxt;
        end
    end

    // blank or over-voltage turns all switches off
    assign blank_off = pins.output_blank; // RULE10
    assign battery_off = pins.battery_sense; // RULE13
    assign outputs_off = blank_off | battery_off;

    // channel n follows latch bit n, bit 0 the newest
    generate
        for (genvar g = 0; g < CHAN_COUNT; g++)
        begin : g_chan_on
            assign chan_on[g] = latch_nxt[g]; // RULE4
        end
    endgenerate

    // a one turns the switch on, a zero keeps it off
    generate
        for (genvar g = 0; g < CHAN_COUNT; g++)
        begin : g_switch
            logic gate_open;

            assign gate_open = ~outputs_off;
            assign switch_nxt[g] = chan_on[g] & gate_open; // RULE11
        end
    endgenerate

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            CHANNEL_SWITCHES <= CHAN_CLEAR;
        end
        else
        begin
            CHANNEL_SWITCHES <= switch_nxt;
        end
    end

    // last stage feeds the cascade output
    assign cascade_nxt = shift_nxt[CHAN_LAST]; // RULE5 RULE6

    always_ff @(posedge SYS_CLK)
    begin
        if (logic_reset)
        begin
            CASCADE_OUT <= 1'b0;
        end
        else
        begin
            CASCADE_OUT <= cascade_nxt;
        end
    end

    // clock sample held for the edge detector
    function automatic logic shift_clk_nxt_hold();
        return shift_clk_prev_nxt;
    endfunction

    // the edge detector, shift stages, latch and switch flops all
    // share logic_reset, so a lockout clears them in one edge

    // the synchroniser itself only obeys RESET, so a lockout
    // never hides the pin that must end it

    // shift clock high and low phases must each last at least two
    // system clocks, or a rise can be lost in the synchroniser

    // serial_in passes the same two stages as the shift clock,
    // so it must stand about two system clocks around each rise

endmodule // led_channel_shift_latch

/* File: verilog/led_latch_pkg.sv */
package led_latch_pkg;

    // channel count and shift register width
    localparam int CHAN_COUNT = 10;
    localparam int CHAN_LAST = CHAN_COUNT - 1;

    // reset value of shift stages, latch and switches
    localparam logic [CHAN_COUNT-1:0] CHAN_CLEAR = 10'h000;

    // synchroniser depth for pin inputs
    localparam int SYNC_DEPTH = 2;

    // pin inputs after synchronisation
    typedef struct packed {
        logic shift_clk;
        logic serial_in;
        logic latch_transfer;
        logic output_blank;
        logic battery_sense;
        logic supply_lockout;
    } pin_in_t;

    localparam pin_in_t PIN_IN_CLEAR = 6'h00;

endpackage

/* File: sim/led_host.sv */
module led_host (input wire logic clk, output logic sck = 1'h0,
    output logic sdo = 1'h0);
    timeunit 1ns; timeprecision 1ns;
    task automatic send(logic [9:0] w);
        for (int i = 9; i >= 0; i--)
        begin
            sck <= 1'h0; sdo <= w[i]; repeat (4) @(posedge clk);
            sck <= 1'h1; repeat (4) @(posedge clk);
        end
        sck <= 1'h0; sdo <= !sdo;
    endtask
endmodule // led_host

/* File: sim/led_sva.sv */
module led_sva
    import led_latch_pkg::*;
(input wire logic SYS_CLK, RESET, SHIFT_CLK, LATCH_TRANSFER, OUTPUT_BLANK,
    BATTERY_SENSE, SUPPLY_LOCKOUT, CASCADE_OUT,
    input wire logic [CHAN_LAST:0] CHANNEL_SWITCHES);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [CHAN_LAST:0] s = CHANNEL_SWITCHES;
    wire logic c = CASCADE_OUT, b = OUTPUT_BLANK, v = BATTERY_SENSE;
    wire logic k = SUPPLY_LOCKOUT, o = LATCH_TRANSFER & !b & !v & !k;
    wire logic h = !LATCH_TRANSFER & !b & !v & !k;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    AST_LK: assert property (k[*5] |-> !s && !c) else $error("f");
    AST_CL: assert property (disable iff (0) RESET[*2] |-> !s && !c)
        else $error("f");
    AST_SH: assert property (o[*8] |-> $stable(s) ||
        (s >> 1) == ($past(s) & 10'h1FF)) else $error("f");
    AST_CA: assert property (o[*8] |-> s[9] == c) else $error("f");
    AST_RO: assert property ($rose(c) |-> $past(SHIFT_CLK, 3))
        else $error("f");
    AST_HO: assert property (h[*5] |-> $stable(s)) else $error("f");
    AST_BL: assert property (b[*4] |-> !s) else $error("f");
    AST_BA: assert property (v[*4] |-> !s) else $error("f");
endmodule // led_sva
bind led_channel_shift_latch led_sva u (.*);

/* File: sim/led_channel_shift_latch_tb.sv */
module led_channel_shift_latch_tb;
    timeunit 1ns; timeprecision 1ns;
    import led_latch_pkg::*;
    logic clk = 0, rst = 1, xl = 0, bl = 1, bat = 0, lo = 0, sck, sd, so;
    logic [CHAN_LAST:0] sw, l = 10'h201;
    logic [31:0] r = 32'h30EA88F5;
    int failures = 0, check_count = 0;
    always #25 clk = !clk;
    led_host host (.clk(clk), .sck(sck), .sdo(sd));
    led_channel_shift_latch DUT (.SYS_CLK(clk), .RESET(rst), .SHIFT_CLK(sck),
        .SERIAL_IN(sd), .LATCH_TRANSFER(xl), .OUTPUT_BLANK(bl),
        .BATTERY_SENSE(bat), .SUPPLY_LOCKOUT(lo), .CASCADE_OUT(so),
        .CHANNEL_SWITCHES(sw));
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [CHAN_COUNT:0] want(logic c);
        return {c, (bl | bat) ? CHAN_CLEAR : l};
    endfunction
    task automatic chk(logic [CHAN_COUNT:0] got, exp);
        check_count++;
        if (got !== exp) failures++;
        if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin #1ms; failures++; print_verdict; end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 0; bl <= 0; xl <= 1;
        repeat (3) @(posedge clk);
        chk({so, sw}, 11'h000);
        host.send(10'h201);
        repeat (6) @(posedge clk);
        chk({so, sw}, 11'h601);
        for (int i = 0; i < 12; i++)
        begin
            r = xs(r);
            xl <= r[0]; bl <= r[1] & r[2]; bat <= r[3] & r[4];
            host.send(r[31:22]);
            repeat (6) @(posedge clk);
            if (xl) l = r[31:22];
            chk({so, sw}, want(r[31]));
            $display("test %0d done", i);
        end
        lo <= 1;
        repeat (6) @(posedge clk);
        chk({so, sw}, 11'h000);
        print_verdict;
    end
endmodule // led_channel_shift_latch_tb
